// File: core/lsm_pkg.sv
/*
 * Shared constants and types of the link speed manager: timing figures,
 * speed codes, clock selections, state codes and the bundles that carry
 * the link engine status and the software-visible status bits.
 * Assumes a single 10 MHz control clock.
 */
package lsm_pkg;
    localparam int unsigned CLK_FREQ_KHZ = 10000;
    localparam int unsigned RESTORE_TIME_MS = 2000;
    localparam int unsigned TRAIN_TIMEOUT_MS = 750;
    localparam int unsigned RESTORE_CYCLES = RESTORE_TIME_MS * CLK_FREQ_KHZ;
    localparam int unsigned TRAIN_CYCLES = TRAIN_TIMEOUT_MS * CLK_FREQ_KHZ;
    localparam logic [1:0] FAIL_LIMIT = 2'h3;
    localparam logic [1:0] STEP_NONE = 2'h0;

    typedef logic [24:0] lsm_tmr_t;

    // Speed field encoding of the link status register
    typedef enum logic [1:0] {
        LSM_SPD_10 = 2'h0,
        LSM_SPD_100 = 2'h1,
        LSM_SPD_1000 = 2'h2
    } lsm_speed_t;

    // One-hot selection of the interface clock source
    localparam logic [2:0] CSEL_FAST = 3'h1;
    localparam logic [2:0] CSEL_MID = 3'h2;
    localparam logic [2:0] CSEL_SLOW = 3'h4;

    typedef enum logic [2:0] {
        LSM_ST_NEG = 3'h1,
        LSM_ST_TRAIN = 3'h2,
        LSM_ST_UP = 3'h4
    } lsm_st_t;

    // Report from the negotiation and training engine
    typedef struct packed {
        logic link_up;
        logic an_done;
        lsm_speed_t speed;
        logic duplex;
        logic lp_pause;
        logic lp_asym;
    } lsm_phy_t;

    // Status bits seen by management software
    typedef struct packed {
        logic isolated;
        logic downgraded;
        logic link_change;
        logic link_ok;
        logic duplex;
        lsm_speed_t speed;
        logic lp_pause;
        logic lp_asym;
    } lsm_status_t;

    typedef struct packed {
        lsm_st_t st;
        lsm_tmr_t tmr;
        lsm_tmr_t rtmr;
        logic restore_run;
        logic lost;
        logic [1:0] fails;
        logic [1:0] steps;
        logic restart_an;
        logic [2:0] csel;
        logic pin_step_s1;
        logic pin_step_s2;
        logic pin_iso_s1;
        logic pin_iso_s2;
        lsm_status_t stat;
    } lsm_state_t;

    localparam lsm_state_t LSM_STATE_RST = '{
        st: LSM_ST_NEG,
        csel: CSEL_MID,
        stat: '{speed: LSM_SPD_10, default: 1'b0},
        default: '0
    };
endpackage

// File: core/lsm_clk_switch.sv
/*
 * Glitch-free switch between three interface clock sources.
 * Assumes the select comes from another domain and every source clock
 * keeps running; each source enables only after the others have let go.
 */
`timescale 1ns/1ns
`default_nettype none
module lsm_clk_switch (
    input wire logic [2:0] clk_src,
    input wire logic rst_b,
    input wire logic [2:0] sel,
    output logic clk_out
);
    wire logic [2:0] en_w;

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_src
            // Each source owns its own flops, two processes per domain
            logic sync1_q;
            logic sync2_q;
            logic en_q;
            always_ff @(posedge clk_src[i]) begin
                sync1_q <= rst_b & sel[i] & ~|(en_w & ~(3'h1 << i));
                sync2_q <= sync1_q;
            end
            // enable changes only while source is low
            always_ff @(negedge clk_src[i]) begin
                en_q <= sync2_q;
            end
            assign en_w[i] = en_q;
            a_en_exclusive: assert property (
                @(posedge clk_src[i]) disable iff (!rst_b) $onehot0(en_w))
                else $error("two clock sources enabled together");
        end
    endgenerate

    assign clk_out = |(clk_src & en_w);
endmodule
`default_nettype wire

// File: core/lsm_core.sv
/*
 * Link speed manager: speed step-down after failed gigabit training,
 * restore of advertised speed after lasting loss of link, isolation of
 * the MAC interface after a speed change, relay of partner pause bits,
 * and selection of the MAC interface clocks.
 * Assumes the negotiation engine reports on the 10 MHz clock and the
 * interface clock sources run continuously.
 */
// Summary of operation
// - No step-down: retry negotiation with same advertisement
// - Three failures lower advertised speed one step
// - Link lost over 2 s restores advertisement
// - Step-down enabled by pin or control bit
// - Link up reports speed in status field
// - Isolation only when enabled, after speed change
// - Isolation blocks MAC traffic until software clears
// - Link changes always flagged in interrupt status
// - Partner pause bits captured after negotiation
// - Clock switch glitch-free within three slow cycles
// - No clock phase shorter than 4 ns
// - Interface clocks follow current link speed
// - Nibble 10 mode keeps clock negotiation to 10
// - Link down restarts negotiation, halts data
// - Link up and duplex reported in status
`timescale 1ns/1ns
`default_nettype none
module lsm_core #(
    parameter int unsigned RESTORE_CYC = lsm_pkg::RESTORE_CYCLES,
    parameter int unsigned TRAIN_CYC = lsm_pkg::TRAIN_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic speed_stepdown_enable_pin,
    input wire logic speed_change_isolate_enable,
    input wire logic cfg_stepdown_en,
    input wire lsm_pkg::lsm_speed_t cfg_max_speed,
    input wire logic cfg_nibble10_mode,
    input wire logic clr_isolated,
    input wire logic clr_downgraded,
    input wire logic clr_link_change,
    input wire lsm_pkg::lsm_phy_t phy,
    input wire logic mac_tx_en_in,
    input wire logic mac_rx_dv_in,
    input wire logic [2:0] tx_clk_src,
    input wire logic [2:0] rx_clk_src,
    output lsm_pkg::lsm_status_t status,
    output lsm_pkg::lsm_speed_t adv_speed,
    output logic restart_an,
    output logic tx_halt,
    output logic mac_tx_en_out,
    output logic mac_rx_dv_out,
    output logic [2:0] clk_sel,
    output logic tx_clk,
    output logic rx_clk
);
    lsm_pkg::lsm_state_t q;
    lsm_pkg::lsm_state_t d;
    logic stepdn;
    logic train_to;
    logic restore_to;
    lsm_pkg::lsm_speed_t adv_now;

    function automatic lsm_pkg::lsm_speed_t spd_minus(
        input lsm_pkg::lsm_speed_t top, input logic [1:0] steps);
        logic [1:0] v;
        v = (top > steps) ? 2'(top - steps) : lsm_pkg::LSM_SPD_10;
        return lsm_pkg::lsm_speed_t'(v);
    endfunction

    function automatic logic [2:0] spd_to_sel(input lsm_pkg::lsm_speed_t s);
        logic [2:0] r;
        r = lsm_pkg::CSEL_SLOW;
        if (s == lsm_pkg::LSM_SPD_1000) begin
            r = lsm_pkg::CSEL_FAST;
        end else if (s == lsm_pkg::LSM_SPD_100) begin
            r = lsm_pkg::CSEL_MID;
        end
        return r;
    endfunction

    assign stepdn = q.pin_step_s2 | cfg_stepdown_en;
    assign train_to = q.tmr == lsm_pkg::lsm_tmr_t'(TRAIN_CYC - 1);
    assign restore_to = q.rtmr == lsm_pkg::lsm_tmr_t'(RESTORE_CYC - 1);
    assign adv_now = spd_minus(cfg_max_speed, q.steps);

    always_comb begin
        d = q;
        d.restart_an = 1'b0;
        d.pin_step_s1 = speed_stepdown_enable_pin;
        d.pin_step_s2 = q.pin_step_s1;
        d.pin_iso_s1 = speed_change_isolate_enable;
        d.pin_iso_s2 = q.pin_iso_s1;
        // Software clears first so hardware sets below win
        if (clr_isolated) begin
            d.stat.isolated = 1'b0;
        end
        if (clr_downgraded) begin
            d.stat.downgraded = 1'b0;
        end
        if (clr_link_change) begin
            d.stat.link_change = 1'b0;
        end
        if (phy.an_done) begin
            d.stat.lp_pause = phy.lp_pause;
            d.stat.lp_asym = phy.lp_asym;
        end
        unique case (q.st)
            lsm_pkg::LSM_ST_NEG: begin
                if (!phy.link_up && phy.an_done &&
                        phy.speed == lsm_pkg::LSM_SPD_1000) begin
                    d.st = lsm_pkg::LSM_ST_TRAIN;
                    d.tmr = '0;
                end
            end
            lsm_pkg::LSM_ST_TRAIN: begin
                if (!phy.link_up && train_to) begin
                    d.st = lsm_pkg::LSM_ST_NEG;
                    d.restart_an = 1'b1;
                    if (stepdn) begin
                        if (q.fails == lsm_pkg::FAIL_LIMIT - 2'h1) begin
                            d.fails = '0;
                            if (adv_now != lsm_pkg::LSM_SPD_10) begin
                                d.steps = q.steps + 2'h1;
                                d.stat.downgraded = 1'b1;
                            end
                        end else begin
                            d.fails = q.fails + 2'h1;
                        end
                    end
                end else if (!phy.link_up) begin
                    d.tmr = q.tmr + 25'h1;
                end
            end
            lsm_pkg::LSM_ST_UP: begin
                if (!phy.link_up) begin
                    d.st = lsm_pkg::LSM_ST_NEG;
                    d.restart_an = 1'b1;
                    d.stat.link_ok = 1'b0;
                    d.stat.link_change = 1'b1;
                    d.lost = 1'b1;
                    d.restore_run = 1'b1;
                    d.rtmr = '0;
                end
            end
        endcase
        if (q.st != lsm_pkg::LSM_ST_UP && phy.link_up) begin
            d.st = lsm_pkg::LSM_ST_UP;
            d.fails = '0;
            d.restore_run = 1'b0;
            d.stat.link_ok = 1'b1;
            d.stat.duplex = phy.duplex;
            d.stat.speed = phy.speed;
            d.stat.link_change = 1'b1;
            if (q.lost && q.pin_iso_s2 && phy.speed != q.stat.speed) begin
                d.stat.isolated = 1'b1;
            end
        end
        if (q.restore_run && q.st != lsm_pkg::LSM_ST_UP) begin
            if (restore_to) begin
                d.steps = lsm_pkg::STEP_NONE;
                d.restore_run = 1'b0;
            end else begin
                d.rtmr = q.rtmr + 25'h1;
            end
        end
        // clock follows link; nibble mode keeps slow clock while link is down
        if (d.stat.link_ok) begin
            d.csel = spd_to_sel(d.stat.speed);
        end else begin
            d.csel = cfg_nibble10_mode ? lsm_pkg::CSEL_SLOW
                                       : lsm_pkg::CSEL_MID;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= lsm_pkg::LSM_STATE_RST;
        end else begin
            q <= d;
        end
    end

    assign status = q.stat;
    assign adv_speed = adv_now;
    assign restart_an = q.restart_an;
    assign tx_halt = ~q.stat.link_ok;
    assign clk_sel = q.csel;
    assign mac_tx_en_out = mac_tx_en_in & q.stat.link_ok & ~q.stat.isolated;
    assign mac_rx_dv_out = mac_rx_dv_in & q.stat.link_ok & ~q.stat.isolated;

    lsm_clk_switch u_tx_sw (
        .clk_src(tx_clk_src),
        .rst_b(rst_b),
        .sel(q.csel),
        .clk_out(tx_clk)
    );
    lsm_clk_switch u_rx_sw (
        .clk_src(rx_clk_src),
        .rst_b(rst_b),
        .sel(q.csel),
        .clk_out(rx_clk)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_train_fail;
        q.st == lsm_pkg::LSM_ST_TRAIN && !phy.link_up && train_to;
    endsequence
    sequence s_link_return;
        q.st != lsm_pkg::LSM_ST_UP && phy.link_up;
    endsequence

    a_no_stepdown: assert property (
        s_train_fail and !stepdn |=> restart_an && q.steps == $past(q.steps)
            && q.st == lsm_pkg::LSM_ST_NEG)
        else $error("advertisement changed without step-down");
    a_step_down: assert property (
        s_train_fail and stepdn && q.fails == 2'h2 &&
            adv_now != lsm_pkg::LSM_SPD_10
        |=> q.steps == $past(q.steps) + 2'h1 && q.fails == 2'h0)
        else $error("no step-down after third failure");
    a_restore_adv: assert property (
        q.restore_run && q.st != lsm_pkg::LSM_ST_UP && restore_to
        |=> q.steps == lsm_pkg::STEP_NONE)
        else $error("advertisement not restored");
    a_enable_src: assert property (
        s_train_fail and stepdn && q.fails == 2'h0 |=> q.fails == 2'h1)
        else $error("failure not counted with step-down enabled");
    a_downgrade_flag: assert property (
        q.steps != $past(q.steps) && q.steps != lsm_pkg::STEP_NONE
        |-> status.downgraded)
        else $error("downgrade not reported");
    a_speed_report: assert property (
        s_link_return |=> status.speed == $past(phy.speed)
            && status.duplex == $past(phy.duplex) && status.link_ok)
        else $error("link speed or duplex not reported");
    a_isolate_set: assert property (
        s_link_return and q.lost && q.pin_iso_s2 &&
            phy.speed != q.stat.speed |=> status.isolated)
        else $error("isolation not set on speed change");
    a_isolate_only: assert property (
        !status.isolated ##1 status.isolated
        |-> $past(q.pin_iso_s2) && $past(phy.link_up))
        else $error("isolation set without cause");
    a_mac_blocked: assert property (
        status.isolated |-> !mac_tx_en_out && !mac_rx_dv_out)
        else $error("traffic passes while isolated");
    a_link_irq: assert property (
        q.st == lsm_pkg::LSM_ST_UP && !phy.link_up |=> status.link_change)
        else $error("link loss not flagged");
    a_partner_bits: assert property (
        phy.an_done |=> status.lp_pause == $past(phy.lp_pause)
            && status.lp_asym == $past(phy.lp_asym))
        else $error("partner pause bits not captured");
    a_clock_follow: assert property (
        status.link_ok |-> clk_sel == spd_to_sel(status.speed))
        else $error("interface clock does not follow speed");
    a_link_down: assert property (
        q.st == lsm_pkg::LSM_ST_UP && !phy.link_up
        |=> restart_an && tx_halt ##1 !restart_an)
        else $error("negotiation not restarted on link loss");
    a_fail_clear: assert property (
        s_link_return |=> q.fails == 2'h0)
        else $error("failure count not cleared");
endmodule
`default_nettype wire

// File: verification/lsm_phy_model.sv
/*
 * Far-side model: engine report of negotiation and training, MAC pause
 * resolution and free-running interface clock sources.
 * Assumes its tasks are called from the bench just after a falling edge.
 */
`timescale 1ns/1ns
`default_nettype none
module lsm_phy_model (
    input wire logic clk,
    output lsm_pkg::lsm_phy_t phy,
    output logic [2:0] clk_src
);
    initial begin
        phy = '0;
        clk_src = 3'h0;
        fork
            forever #4 clk_src[0] = ~clk_src[0];
            forever #20 clk_src[1] = ~clk_src[1];
            forever #200 clk_src[2] = ~clk_src[2];
        join
    end

    // MAC pause resolution
    // Bit 1: local may pause remote; bit 0: remote may pause local
    function automatic logic [1:0] resolve(input logic lp, la, rp, ra);
        return (la & ra) ? {rp, lp} : {2{lp & rp}};
    endfunction

    task automatic set_link(input logic u, input lsm_pkg::lsm_speed_t s);
        @(negedge clk);
        phy = '{link_up: u, an_done: u, speed: s, duplex: u, lp_pause: u,
                lp_asym: s[1]};
    endtask

    task automatic fail_train();
        @(negedge clk);
        phy = '{an_done: 1'b1, speed: lsm_pkg::LSM_SPD_1000, default: 1'b0};
        @(negedge clk);
        phy.an_done = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: verification/lsm_core_tb_top.sv
/*
 * Self-checking bench of the link speed manager core.
 * Assumes the far-side model drives the engine report and clock sources.
 */
`timescale 1ns/1ns
`default_nettype none
module lsm_core_tb_top;
    localparam int unsigned RCYC = 50;
    localparam int unsigned TCYC = 20;
    logic clk, rst_b, pin, iso, cfg, nib, clr_i, clr_d, clr_l, tx_en, rx_dv;
    lsm_pkg::lsm_phy_t phy;
    lsm_pkg::lsm_status_t status;
    lsm_pkg::lsm_speed_t adv, max_spd;
    logic [2:0] src, sel;
    logic rst_an, halt, tx_o, rx_o, tx_clk, rx_clk;
    logic mon = 1'b0;
    int failures = 0, checks_done = 0, tx_n = 0, rx_n = 0;
    time t_last = 0;

    lsm_phy_model PRT (.clk(clk), .phy(phy), .clk_src(src));
    lsm_core #(.RESTORE_CYC(RCYC), .TRAIN_CYC(TCYC)) DUT (
        .clk(clk), .rst_b(rst_b), .speed_stepdown_enable_pin(pin),
        .speed_change_isolate_enable(iso), .cfg_stepdown_en(cfg),
        .cfg_max_speed(max_spd), .cfg_nibble10_mode(nib),
        .clr_isolated(clr_i), .clr_downgraded(clr_d),
        .clr_link_change(clr_l), .phy(phy), .mac_tx_en_in(tx_en),
        .mac_rx_dv_in(rx_dv), .tx_clk_src(src), .rx_clk_src(src),
        .status(status), .adv_speed(adv), .restart_an(rst_an),
        .tx_halt(halt), .mac_tx_en_out(tx_o), .mac_rx_dv_out(rx_o),
        .clk_sel(sel), .tx_clk(tx_clk), .rx_clk(rx_clk));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge tx_clk) tx_n++;
    always @(posedge rx_clk) rx_n++;
    // Shortest phase allowed on a switched clock
    always @(tx_clk) begin
        if (mon && $time - t_last < 4) begin
            failures++;
            $display("ERROR t=%0t phase=%0h exp=%0h", $time, $time - t_last,
                     4);
        end
        t_last = $time;
    end

    task automatic test_done();
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic clr(input logic [2:0] m);
        {clr_i, clr_d, clr_l} = m;
        cyc(1);
        {clr_i, clr_d, clr_l} = 3'h0;
        cyc(1);
    endtask

    task automatic t_clk(input logic [2:0] s, input int lo, input int hi);
        int n0, r0;
        chk(16'(sel), 16'(s));
        cyc(25);
        n0 = tx_n;
        r0 = rx_n;
        cyc(10);
        chk(16'(tx_n - n0 >= lo && tx_n - n0 <= hi), 16'h1);
        chk(16'(rx_n - r0 >= lo && rx_n - r0 <= hi), 16'h1);
    endtask

    task automatic up(input lsm_pkg::lsm_speed_t s);
        PRT.set_link(1'b1, s);
        cyc(1);
    endtask

    task automatic drop();
        PRT.set_link(1'b0, lsm_pkg::LSM_SPD_10);
        cyc(1);
        chk(16'({rst_an, halt}), 16'h3);
        chk(16'({status.link_ok, tx_o, rx_o}), 16'h0);
        chk(16'(status.link_change), 16'h1);
        cyc(2);
    endtask

    task automatic fail();
        int k;
        k = 0;
        PRT.fail_train();
        while (rst_an !== 1'b1 && k < TCYC + 10) begin
            cyc(1);
            k++;
        end
        chk(16'(rst_an), 16'h1);
        cyc(1);
    endtask

    task automatic chk_fc(input logic lp, la, input logic [1:0] e);
        chk(16'(PRT.resolve(lp, la, status.lp_pause, status.lp_asym)),
            16'(e));
    endtask

    task automatic exp_adv(input lsm_pkg::lsm_speed_t s, input logic d);
        chk(16'(adv), 16'(s));
        chk(16'(status.downgraded), 16'(d));
    endtask

    task automatic t_reset();
        chk(16'(status), 16'h0);
        chk(16'(halt), 16'h1);
        exp_adv(lsm_pkg::LSM_SPD_1000, 1'b0);
        max_spd = lsm_pkg::LSM_SPD_100;
        cyc(1);
        chk(16'(adv), 16'(lsm_pkg::LSM_SPD_100));
        max_spd = lsm_pkg::LSM_SPD_1000;
        cyc(1);
        t_clk(lsm_pkg::CSEL_MID, 24, 26);
    endtask

    task automatic t_up();
        lsm_pkg::lsm_status_t e;
        e = '{link_change: 1'b1, link_ok: 1'b1, duplex: 1'b1,
              speed: lsm_pkg::LSM_SPD_100, lp_pause: 1'b1, default: 1'b0};
        up(lsm_pkg::LSM_SPD_100);
        chk(16'(status), 16'(e));
        chk_fc(1'b1, 1'b1, 2'h3);
        chk_fc(1'b0, 1'b1, 2'h0);
        chk(16'({halt, tx_o, rx_o}), 16'h3);
        t_clk(lsm_pkg::CSEL_MID, 24, 26);
        clr(3'h1);
        chk(16'(status.link_change), 16'h0);
        drop();
    endtask

    task automatic t_nostep();
        repeat (4) fail();
        exp_adv(lsm_pkg::LSM_SPD_1000, 1'b0);
    endtask

    task automatic t_step();
        cfg = 1'b1;
        repeat (2) fail();
        up(lsm_pkg::LSM_SPD_100);
        drop();
        repeat (2) fail();
        exp_adv(lsm_pkg::LSM_SPD_1000, 1'b0);
        fail();
        exp_adv(lsm_pkg::LSM_SPD_100, 1'b1);
        clr(3'h2);
        cfg = 1'b0;
        pin = 1'b1;
        cyc(3);
        repeat (3) fail();
        exp_adv(lsm_pkg::LSM_SPD_10, 1'b1);
        clr(3'h2);
        repeat (3) fail();
        exp_adv(lsm_pkg::LSM_SPD_10, 1'b0);
        pin = 1'b0;
    endtask

    task automatic t_restore();
        up(lsm_pkg::LSM_SPD_10);
        drop();
        cyc(RCYC - 8);
        chk(16'(adv), 16'(lsm_pkg::LSM_SPD_10));
        cyc(12);
        chk(16'(adv), 16'(lsm_pkg::LSM_SPD_1000));
    endtask

    task automatic t_iso();
        up(lsm_pkg::LSM_SPD_1000);
        t_clk(lsm_pkg::CSEL_FAST, 124, 126);
        chk_fc(1'b0, 1'b1, 2'h2);
        chk_fc(1'b1, 1'b1, 2'h3);
        iso = 1'b1;
        cyc(3);
        drop();
        up(lsm_pkg::LSM_SPD_100);
        chk(16'({status.isolated, tx_o, rx_o}), 16'h4);
        t_clk(lsm_pkg::CSEL_MID, 24, 26);
        chk(16'({status.isolated, tx_o, rx_o}), 16'h4);
        clr(3'h4);
        chk(16'({status.isolated, tx_o, rx_o}), 16'h3);
        iso = 1'b0;
        cyc(3);
        drop();
        clr(3'h1);
        up(lsm_pkg::LSM_SPD_1000);
        chk(16'({status.isolated, status.link_change}), 16'h1);
        drop();
    endtask

    task automatic t_nib();
        nib = 1'b1;
        up(lsm_pkg::LSM_SPD_100);
        drop();
        t_clk(lsm_pkg::CSEL_SLOW, 2, 3);
        up(lsm_pkg::LSM_SPD_10);
        t_clk(lsm_pkg::CSEL_SLOW, 2, 3);
        nib = 1'b0;
        drop();
        t_clk(lsm_pkg::CSEL_MID, 24, 26);
    endtask

    initial begin
        {rst_b, pin, iso, cfg, nib, clr_i, clr_d, clr_l} = 8'h00;
        {tx_en, rx_dv} = 2'h3;
        max_spd = lsm_pkg::LSM_SPD_1000;
        cyc(20);
        rst_b = 1'b1;
        cyc(30);
        mon = 1'b1;
        t_reset();
        t_up();
        t_nostep();
        t_step();
        t_restore();
        t_iso();
        t_nib();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
